// >>> ess_checker.sv
// Purpose: Port assertions for the sequencer
// Assumes: One aclk domain
// Notes:   Bound from the testbench top
`timescale 1ns/10ps
`default_nettype none
module ess_checker (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire ess_pkg::ess_relay_s relays,
  input wire logic                load_ready,
  input wire logic                low_checks_enable,
  input wire logic                fuel_loss_msg
);
  // ==========
  // Properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_preheat_fuel: assert property (relays.preheat |-> relays.fuel)
    else $error("preheat without fuel");
  a_crank_fuel: assert property (relays.crank |-> relays.fuel && !relays.preheat)
    else $error("crank without fuel");
  a_choke_crank: assert property (relays.choke |-> relays.crank)
    else $error("choke outside cranking");
  a_gas_crank: assert property ($rose(relays.gas) |-> relays.crank)
    else $error("gas opened outside cranking");
  a_idle_checks: assert property (relays.idle |-> !low_checks_enable)
    else $error("low checks during idle");
  a_load_heated: assert property (load_ready |-> !relays.idle && !relays.crank)
    else $error("load while starting or idling");
  a_stop_nofuel: assert property (relays.stop |-> !relays.fuel && !load_ready)
    else $error("stop with fuel or load");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_msg_pulse: assert property (fuel_loss_msg |=> !fuel_loss_msg)
    else $error("fuel message longer than a cycle");
endmodule : ess_checker
`default_nettype wire

// >>> ess_engine_model.sv
// Purpose: Engine behind the relays
// Assumes: Fires after five crank cycles when allowed
// Notes:   stuck keeps it running after fuel cut
`timescale 1ns/10ps
`default_nettype none
module ess_engine_model (
  input wire logic                aclk,
  input wire ess_pkg::ess_relay_s relays,
  input wire logic                fire_en,
  input wire logic                stuck,
  output logic                    running
);
  logic [2:0] crank_cnt = 3'h0;
  initial running = 1'b0;
  always @(posedge aclk) begin
    crank_cnt <= relays.crank ? crank_cnt + 3'h1 : 3'h0;
    if (fire_en && crank_cnt == 3'h4) begin
      running <= 1'b1;
    end else if (!relays.fuel && !stuck) begin
      running <= 1'b0;
    end
  end
endmodule : ess_engine_model
`default_nettype wire

// >>> ess_pkg.sv
// Purpose: Shared constants and types for the engine start/stop sequencer
// Assumes: 32-bit AXI4-Lite register space, one-second tick from aclk
// Notes:   Offsets are byte addresses; every timer field is in seconds but the start delay
package ess_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_TIM0   = 8'h04;
  localparam logic [7:0]  OFS_TIM1   = 8'h08;
  localparam logic [7:0]  OFS_TIM2   = 8'h0C;
  localparam logic [7:0]  OFS_TIM3   = 8'h10;
  localparam logic [7:0]  OFS_OPT    = 8'h14;
  localparam logic [7:0]  OFS_STATUS = 8'h18;
  localparam logic [7:0]  OFS_EVENT  = 8'h1C;
  // ==========================================================================
  // Reset values
  localparam logic [31:0] RST_CTRL   = 32'h0000_0000;
  localparam logic [31:0] RST_TIM0   = 32'h0600_0001;
  localparam logic [31:0] RST_TIM1   = 32'h0505_040A;
  localparam logic [31:0] RST_TIM2   = 32'h0078_0000;
  localparam logic [31:0] RST_TIM3   = 32'h0102_0A0A;
  localparam logic [31:0] RST_OPT    = 32'h0000_0003;
  // ==========================================================================
  // Event bit positions
  localparam int EV_START_FAIL = 0;
  localparam int EV_STOP_FAIL  = 1;
  localparam int EV_CHARGE     = 2;
  localparam int EV_FUEL_LOSS  = 3;
  localparam int EV_REFUEL     = 4;
  localparam int EV_W          = 5;
  // ==========================================================================
  // Input pin positions
  localparam int IN_MAINS_FAIL = 0;
  localparam int IN_VOLT       = 1;
  localparam int IN_FREQ       = 2;
  localparam int IN_RPM        = 3;
  localparam int IN_CHG_OK     = 4;
  localparam int IN_CHG_LOW    = 5;
  localparam int IN_OIL_SW     = 6;
  localparam int IN_OIL_HI     = 7;
  localparam int IN_COOL_HOT   = 8;
  localparam int IN_FUEL_LOSS  = 9;
  localparam int IN_REFUEL     = 10;
  localparam int IN_W          = 11;
  // ==========================================================================
  // Timing
  localparam int          CLK_HZ      = 200_000_000;
  localparam int          TICK_SEC    = 1;
  localparam int          TICK_CYCLES = CLK_HZ * TICK_SEC;
  localparam logic [15:0] SEC_PER_MIN = 16'h003C;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_OFF      = 4'h0,
    ST_DELAY    = 4'h1,
    ST_PREHEAT  = 4'h2,
    ST_CRANK    = 4'h3,
    ST_REST     = 4'h4,
    ST_IDLE_RUN = 4'h5,
    ST_HEAT     = 4'h6,
    ST_LOADED   = 4'h7,
    ST_COOL     = 4'h8,
    ST_IDLE_STP = 4'h9,
    ST_STOPPING = 4'hA,
    ST_FAILED   = 4'hB
  } ess_state_e;

  typedef struct packed {
    logic fuel;
    logic preheat;
    logic crank;
    logic choke;
    logic gas;
    logic idle;
    logic stop;
  } ess_relay_s;
endpackage : ess_pkg

// >>> ess_sequencer.sv
// Purpose: Engine start/stop sequencer with AXI4-Lite configuration
// Assumes: Comparator results arrive as asynchronous level pins
// Notes:   The state timer restarts on every state change; charge and holdoff timers run across states
//
// Behaviour
// - Charge fault after charge voltage stays low for whole charge fail time.
// - After mains failure wait start delay in minutes, then energize fuel.
// - Preheat active for preheat time after fuel on, before cranking.
// - Crank attempt lasts at most crank time, ends early when engine fires.
// - Pause between attempts; number of attempts limited to configured count.
// - No load before heating done; method 1 also waits for coolant temperature.
// - Heating time configurable, 0 to 255 seconds, default 4.
// - After mains return run unloaded for cooldown time before stopping.
// - Stop output until engine stops, at most stop time; still running afterwards raises warning.
// - Choke on with crank, off after choke delay or engine running.
// - Idle output for idle-run time after start; low checks suppressed.
// - Idle output for idle-stop time before stop; low checks suppressed.
// - Low checks re-enabled only after holdoff following an idle period.
// - Gas solenoid opens during cranking after the gas delay.
// - Crank cut on L1 voltage, frequency, speed or charge voltage reached.
// - Charge voltage crank cut only when charge input connected is set.
// - Oil crank cut, when enabled, after delay on oil switch or pressure.
// - Fuel consumption threshold gates fuel-loss and refuel messages; 0 suppresses.
`timescale 1ns/10ps
`default_nettype none
module ess_sequencer #(
  parameter int TICK_CYCLES = ess_pkg::TICK_CYCLES
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic [ess_pkg::IN_W-1:0] sense_pins,
  output ess_pkg::ess_relay_s         relays,
  output logic                        load_ready,
  output logic                        low_checks_enable,
  output logic                        stop_failure_warning,
  output logic                        fuel_loss_msg,
  output logic                        refuel_msg
);
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic done(input logic [15:0] cnt, input logic [15:0] lim);
    return cnt >= lim;
  endfunction : done

  // ==========================================================================
  // Input synchronisers
  logic [ess_pkg::IN_W-1:0] sync_a;
  logic [ess_pkg::IN_W-1:0] sync_b;
  logic [ess_pkg::IN_W-1:0] sync_d;
  always_ff @(posedge aclk) begin
    sync_a <= sense_pins;
    sync_b <= sync_a;
    sync_d <= aresetn ? sync_b : '0;
  end

  wire logic mains_fail = sync_b[ess_pkg::IN_MAINS_FAIL];
  wire logic chg_low    = sync_b[ess_pkg::IN_CHG_LOW];
  wire logic cool_hot   = sync_b[ess_pkg::IN_COOL_HOT];
  wire logic oil_cond   = sync_b[ess_pkg::IN_OIL_SW] | sync_b[ess_pkg::IN_OIL_HI];
  wire logic fuel_rise  = sync_b[ess_pkg::IN_FUEL_LOSS] & ~sync_d[ess_pkg::IN_FUEL_LOSS];
  wire logic refl_rise  = sync_b[ess_pkg::IN_REFUEL] & ~sync_d[ess_pkg::IN_REFUEL];

  // ==========================================================================
  // Registers
  logic [31:0]             reg_ctrl;
  logic [31:0]             reg_tim0;
  logic [31:0]             reg_tim1;
  logic [31:0]             reg_tim2;
  logic [31:0]             reg_tim3;
  logic [31:0]             reg_opt;
  logic [ess_pkg::EV_W-1:0] events;
  logic [ess_pkg::EV_W-1:0] ev_set;

  wire logic        seq_enable  = reg_ctrl[0];
  wire logic [15:0] t_start_min = {6'h00, reg_tim0[9:0]};
  wire logic [15:0] t_preheat   = {11'h000, reg_tim0[20:16]};
  wire logic [15:0] t_crank     = {12'h000, reg_tim0[27:24]};
  wire logic [15:0] t_rest      = {8'h00, reg_tim1[7:0]};
  wire logic [15:0] t_heat      = {8'h00, reg_tim1[15:8]};
  wire logic [15:0] t_choke     = {8'h00, reg_tim1[23:16]};
  wire logic [15:0] t_gas       = {8'h00, reg_tim1[31:24]};
  wire logic [15:0] t_idle_run  = {8'h00, reg_tim2[7:0]};
  wire logic [15:0] t_idle_stp  = {8'h00, reg_tim2[15:8]};
  wire logic [15:0] t_cool      = {6'h00, reg_tim2[25:16]};
  wire logic [15:0] t_stop      = {9'h000, reg_tim3[6:0]};
  wire logic [15:0] t_holdoff   = {11'h000, reg_tim3[12:8]};
  wire logic [15:0] t_oil       = {11'h000, reg_tim3[20:16]};
  wire logic [15:0] t_chg_fail  = {9'h000, reg_tim3[30:24]};
  wire logic [2:0]  n_starts    = reg_opt[2:0];
  wire logic        heat_method = reg_opt[4];
  wire logic        oil_cut_en  = reg_opt[5];
  wire logic        chg_conn    = reg_opt[6];
  wire logic [6:0]  fuel_thr    = reg_opt[14:8];

  // Start delay held in minutes; compared in ticks, fits 720*60 in 16 bits
  wire logic [15:0] t_start_sec = 16'(t_start_min * ess_pkg::SEC_PER_MIN);

  // ==========================================================================
  // Sequencer state and timers
  ess_pkg::ess_state_e state;
  ess_pkg::ess_state_e next_state;
  logic [31:0]         tick_div;
  logic                tick;
  logic [15:0]         secs;
  logic [15:0]         oil_secs;
  logic [15:0]         chg_secs;
  logic [15:0]         hold_secs;
  logic [2:0]          attempts;

  wire logic st_change = (next_state != state);
  wire logic firing    = sync_b[ess_pkg::IN_VOLT] | sync_b[ess_pkg::IN_FREQ]
                       | sync_b[ess_pkg::IN_RPM]
                       | (chg_conn & sync_b[ess_pkg::IN_CHG_OK]);
  wire logic oil_cut   = oil_cut_en & oil_cond & done(oil_secs, t_oil);
  wire logic crank_cut = firing | oil_cut;
  wire logic running   = sync_b[ess_pkg::IN_VOLT] | sync_b[ess_pkg::IN_FREQ]
                       | sync_b[ess_pkg::IN_RPM];
  wire logic eng_on    = (state >= ess_pkg::ST_IDLE_RUN) && (state <= ess_pkg::ST_STOPPING);
  wire logic in_idle   = (state == ess_pkg::ST_IDLE_RUN) || (state == ess_pkg::ST_IDLE_STP);
  wire logic last_try  = (attempts + 3'h1) >= n_starts;
  wire logic heat_done = done(secs, t_heat) & (~heat_method | cool_hot);

  // Divider restarts on entry so a state's first second is a full one
  always_ff @(posedge aclk) begin
    if (!aresetn || st_change || tick) begin
      tick_div <= '0;
    end else begin
      tick_div <= tick_div + 32'h0000_0001;
    end
  end
  assign tick = (tick_div == 32'(TICK_CYCLES - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn || st_change) begin
      secs <= '0;
    end else if (tick && secs != 16'hFFFF) begin
      secs <= secs + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state != ess_pkg::ST_CRANK || !oil_cond) begin
      oil_secs <= '0;
    end else if (tick && oil_secs != 16'hFFFF) begin
      oil_secs <= oil_secs + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !eng_on || !chg_low) begin
      chg_secs <= '0;
    end else if (tick && chg_secs != 16'hFFFF) begin
      chg_secs <= chg_secs + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || in_idle || !eng_on) begin
      hold_secs <= '0;
    end else if (tick && hold_secs != 16'hFFFF) begin
      hold_secs <= hold_secs + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state == ess_pkg::ST_OFF) begin
      attempts <= '0;
    end else if (state == ess_pkg::ST_CRANK && next_state == ess_pkg::ST_REST) begin
      attempts <= attempts + 3'h1;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ess_pkg::ST_OFF: begin
        if (seq_enable && mains_fail) next_state = ess_pkg::ST_DELAY;
      end
      ess_pkg::ST_DELAY: begin
        if (!mains_fail) next_state = ess_pkg::ST_OFF;
        else if (done(secs, t_start_sec)) next_state = ess_pkg::ST_PREHEAT;
      end
      ess_pkg::ST_PREHEAT: begin
        if (done(secs, t_preheat)) next_state = ess_pkg::ST_CRANK;
      end
      ess_pkg::ST_CRANK: begin
        if (crank_cut) next_state = ess_pkg::ST_IDLE_RUN;
        else if (done(secs, t_crank)) begin
          next_state = last_try ? ess_pkg::ST_FAILED : ess_pkg::ST_REST;
        end
      end
      ess_pkg::ST_REST: begin
        if (done(secs, t_rest)) next_state = ess_pkg::ST_CRANK;
      end
      ess_pkg::ST_IDLE_RUN: begin
        if (done(secs, t_idle_run)) next_state = ess_pkg::ST_HEAT;
      end
      ess_pkg::ST_HEAT: begin
        if (heat_done) next_state = ess_pkg::ST_LOADED;
      end
      ess_pkg::ST_LOADED: begin
        if (!mains_fail) next_state = ess_pkg::ST_COOL;
      end
      ess_pkg::ST_COOL: begin
        if (mains_fail) next_state = ess_pkg::ST_LOADED;
        else if (done(secs, t_cool)) next_state = ess_pkg::ST_IDLE_STP;
      end
      ess_pkg::ST_IDLE_STP: begin
        if (done(secs, t_idle_stp)) next_state = ess_pkg::ST_STOPPING;
      end
      ess_pkg::ST_STOPPING: begin
        if (!running || done(secs, t_stop)) next_state = ess_pkg::ST_OFF;
      end
      ess_pkg::ST_FAILED: begin
        if (!seq_enable) next_state = ess_pkg::ST_OFF;
      end
      default: next_state = ess_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ess_pkg::ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Relay outputs, registered
  wire logic cranking = (state == ess_pkg::ST_CRANK) && !crank_cut;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      relays <= '0;
    end else begin
      relays.fuel    <= (state >= ess_pkg::ST_PREHEAT) && (state <= ess_pkg::ST_IDLE_STP);
      relays.preheat <= (state == ess_pkg::ST_PREHEAT);
      relays.crank   <= cranking;
      relays.choke   <= cranking && !done(secs, t_choke) && !running;
      relays.gas     <= cranking && done(secs, t_gas);
      relays.idle    <= in_idle;
      relays.stop    <= (state == ess_pkg::ST_STOPPING);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_ready        <= 1'b0;
      low_checks_enable <= 1'b0;
      fuel_loss_msg     <= 1'b0;
      refuel_msg        <= 1'b0;
    end else begin
      load_ready        <= (state == ess_pkg::ST_LOADED);
      low_checks_enable <= eng_on && !in_idle && done(hold_secs, t_holdoff);
      fuel_loss_msg     <= fuel_rise && (fuel_thr != 7'h00);
      refuel_msg        <= refl_rise && (fuel_thr != 7'h00);
    end
  end

  // ==========================================================================
  // Sticky events
  always_comb begin
    ev_set = '0;
    ev_set[ess_pkg::EV_START_FAIL] = (state == ess_pkg::ST_CRANK)
                                   && (next_state == ess_pkg::ST_FAILED);
    ev_set[ess_pkg::EV_STOP_FAIL]  = (state == ess_pkg::ST_STOPPING) && running
                                   && done(secs, t_stop);
    ev_set[ess_pkg::EV_CHARGE]     = eng_on && chg_low && done(chg_secs, t_chg_fail);
    ev_set[ess_pkg::EV_FUEL_LOSS]  = fuel_rise && (fuel_thr != 7'h00);
    ev_set[ess_pkg::EV_REFUEL]     = refl_rise && (fuel_thr != 7'h00);
  end
  assign stop_failure_warning = events[ess_pkg::EV_STOP_FAIL];

  // ==========================================================================
  // AXI4-Lite write channel
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  wire logic aw_go  = s_axi_awvalid && s_axi_awready;
  wire logic w_go   = s_axi_wvalid && s_axi_wready;
  wire logic wr_do  = (aw_held || aw_go) && (w_held || w_go);
  wire logic [7:0]  wa = aw_held ? aw_addr : s_axi_awaddr;
  wire logic [31:0] wd = w_held ? w_data : s_axi_wdata;
  wire logic [3:0]  ws = w_held ? w_strb : s_axi_wstrb;
  wire logic wa_ok = (wa <= ess_pkg::OFS_EVENT) && (wa[1:0] == 2'b00)
                     && (wa != ess_pkg::OFS_STATUS);
  wire logic [31:0] ev_clr = (wr_do && wa == ess_pkg::OFS_EVENT)
                             ? merge(32'h0, wd, ws) : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      if (aw_go) aw_addr <= s_axi_awaddr;
      if (w_go) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      aw_held <= wr_do ? 1'b0 : (aw_held | aw_go);
      w_held  <= wr_do ? 1'b0 : (w_held | w_go);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ess_pkg::RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wa_ok ? ess_pkg::RESP_OKAY : ess_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reg_ctrl <= ess_pkg::RST_CTRL;
      reg_tim0 <= ess_pkg::RST_TIM0;
      reg_tim1 <= ess_pkg::RST_TIM1;
      reg_tim2 <= ess_pkg::RST_TIM2;
      reg_tim3 <= ess_pkg::RST_TIM3;
      reg_opt  <= ess_pkg::RST_OPT;
    end else if (wr_do) begin
      if (wa == ess_pkg::OFS_CTRL) reg_ctrl <= merge(reg_ctrl, wd, ws) & 32'h0000_0001;
      if (wa == ess_pkg::OFS_TIM0) reg_tim0 <= merge(reg_tim0, wd, ws) & 32'h0F1F_03FF;
      if (wa == ess_pkg::OFS_TIM1) reg_tim1 <= merge(reg_tim1, wd, ws);
      if (wa == ess_pkg::OFS_TIM2) reg_tim2 <= merge(reg_tim2, wd, ws) & 32'h03FF_FFFF;
      if (wa == ess_pkg::OFS_TIM3) reg_tim3 <= merge(reg_tim3, wd, ws) & 32'h7F1F_1F7F;
      if (wa == ess_pkg::OFS_OPT)  reg_opt  <= merge(reg_opt, wd, ws) & 32'h0000_7F77;
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      events <= '0;
    end else begin
      events <= (events & ~ev_clr[ess_pkg::EV_W-1:0]) | ev_set;
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;
  wire logic [7:0] ra = s_axi_araddr;
  wire logic [31:0] status_word = {16'h0000, relays, load_ready,
                                   low_checks_enable, attempts, state};
  wire logic [31:0] rd_mux =
      (ra == ess_pkg::OFS_CTRL)   ? reg_ctrl :
      (ra == ess_pkg::OFS_TIM0)   ? reg_tim0 :
      (ra == ess_pkg::OFS_TIM1)   ? reg_tim1 :
      (ra == ess_pkg::OFS_TIM2)   ? reg_tim2 :
      (ra == ess_pkg::OFS_TIM3)   ? reg_tim3 :
      (ra == ess_pkg::OFS_OPT)    ? reg_opt  :
      (ra == ess_pkg::OFS_STATUS) ? status_word :
      (ra == ess_pkg::OFS_EVENT)  ? {27'h0, events} : 32'h0;
  wire logic ra_ok = (ra <= ess_pkg::OFS_EVENT) && (ra[1:0] == 2'b00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= ess_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= ra_ok ? rd_mux : 32'h0;
      s_axi_rresp  <= ra_ok ? ess_pkg::RESP_OKAY : ess_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : ess_sequencer
`default_nettype wire

// >>> tb_engine_start_stop_sequencer.sv
// Purpose: Register and start/stop sequence tests
// Assumes: TICK_CYCLES of 10, so one second is 10 cycles
// Notes:   bready, rready and wstrb held constant
`timescale 1ns/10ps
`default_nettype none
module tb_engine_start_stop_sequencer;
  logic aclk, aresetn, awvalid, wvalid, arvalid, fire_en, stuck, running, prev;
  logic awready, wready, bvalid, rvalid, load_ready, warn, lce, flm, rfm, arready_w;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [10:0] pins;
  ess_pkg::ess_relay_s relays;
  int mismatches, checks_done, cranks, base, pulses;
  logic [7:0] ofs [5] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [31:0] rst [5] = '{ess_pkg::RST_TIM0, ess_pkg::RST_TIM1, ess_pkg::RST_TIM2,
                           ess_pkg::RST_TIM3, ess_pkg::RST_OPT};
  logic [31:0] cfg [5] = '{32'h0201_0000, 32'h0101_0101, 32'h0001_0101,
                           32'h0102_0102, 32'h0000_0002};
  ess_sequencer #(.TICK_CYCLES(10)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready_w),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .sense_pins({pins[10:4], {3{running}}, pins[0]}), .relays(relays),
    .load_ready(load_ready), .low_checks_enable(lce), .stop_failure_warning(warn),
    .fuel_loss_msg(flm), .refuel_msg(rfm));
  ess_engine_model eng_u (.aclk(aclk), .relays(relays), .fire_en(fire_en),
    .stuck(stuck), .running(running));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    prev <= relays.crank;
    if (relays.crank && !prev) cranks <= cranks + 1;
    pulses <= pulses + int'(flm) + int'(rfm);
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready_w) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    resp = rresp;
  endtask : rd
  task wait_state(input logic [3:0] s);
    int n;
    d = {28'h0, ~s};
    for (n = 0; n < 300 && d[3:0] !== s; n++) rd(8'h18, d, r);
    chk(32'(d[3:0]), 32'(s));
  endtask : wait_state
  task final_report;
    $display("checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
  initial begin
    {aresetn, awvalid, wvalid, arvalid, fire_en, stuck, prev} = 7'h00;
    {awaddr, araddr, wdata, pins, cranks, pulses, mismatches, checks_done} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (ofs[i]) begin
      rd(ofs[i], d, r);
      chk(d, rst[i]);
    end
    rd(8'h20, d, r);
    chk(32'(r), 32'(ess_pkg::RESP_SLVERR));
    wr(8'h18, 32'h0, r);
    chk(32'(r), 32'(ess_pkg::RESP_SLVERR));
    foreach (ofs[i]) wr(ofs[i], cfg[i], r);
    $display("test registers done");
    // ==========
    // Engine never fires; fuel-loss pin with zero threshold
    pins[0] <= 1'b1;
    pins[9] <= 1'b1;
    wr(8'h00, 32'h1, r);
    wait_state(4'hB);
    chk(cranks, 2);
    chk(32'(relays), 32'h0);
    rd(8'h1C, d, r);
    chk(d, 32'h1);
    $display("test start failure done");
    // ==========
    // Engine fires but will not stop
    wr(8'h1C, 32'h1F, r);
    wr(8'h00, 32'h0, r);
    base = cranks;
    fire_en <= 1'b1;
    stuck <= 1'b1;
    wr(8'h00, 32'h1, r);
    wait_state(4'h7);
    chk(cranks - base, 1);
    chk({24'h0, load_ready, relays}, 32'hC0);
    chk(32'(lce), 32'h1);
    pins[0] <= 1'b0;
    wait_state(4'h0);
    chk(32'(warn), 32'h1);
    rd(8'h1C, d, r);
    chk(d, 32'h2);
    $display("test stop failure done");
    // ==========
    // Fuel messages with a nonzero threshold
    wr(8'h14, 32'h0000_0102, r);
    {pins[9], pins[10]} <= 2'b00;
    repeat (4) @(posedge aclk);
    {pins[9], pins[10]} <= 2'b11;
    repeat (6) @(posedge aclk);
    chk(pulses, 2);
    rd(8'h1C, d, r);
    chk(d, 32'h1A);
    $display("test fuel messages done");
    final_report();
  end
endmodule : tb_engine_start_stop_sequencer
bind ess_sequencer ess_checker chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .relays(relays), .load_ready(load_ready),
  .low_checks_enable(low_checks_enable), .fuel_loss_msg(fuel_loss_msg));
`default_nettype wire
